// ### design/swc_pkg.sv
// Shared constants and types of the sleep mode and CTS wake controller.
// Assumes a single 20 MHz clock and a Wishbone register slave.
package swc_pkg;
  // Clock rate in Hz.
  localparam int CLK_HZ = 20_000_000;
  // Clock period in ns.
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  // Radio frame length in ns, 4.616 ms.
  localparam int FRAME_NS = 4_616_000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  // Frames in one paging multiframe.
  localparam int FRAMES_PER_PAGE = 51;
  // CTS-low listen slot and the UART slot after it, 5 ms each.
  localparam int LISTEN_MS = 5;
  localparam int LISTEN_CYC = LISTEN_MS * (CLK_HZ / 1000);
  // Resolution of the follow-up hold timer, 100 ms.
  localparam int TENTH_MS = 100;
  localparam int TENTH_CYC = TENTH_MS * (CLK_HZ / 1000);
  // Longest receive delay after an RTS wake-up, 60 ms.
  localparam int WAKE_MS = 60;
  localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
  // Functionality level codes.
  localparam logic [3:0] FUN_NC = 4'h0;
  localparam logic [3:0] FUN_FULL = 4'h1;
  localparam logic [3:0] FUN_C7 = 4'h7;
  localparam logic [3:0] FUN_C9 = 4'h9;
  // Reception factor range and reset value.
  localparam logic [3:0] DRX_MIN = 4'h2;
  localparam logic [3:0] DRX_MAX = 4'h9;
  localparam logic [3:0] DRX_RST = 4'h2;
  // Follow-up time in tenths of a second: 0.5 s to 1 h, 2 s default.
  localparam logic [15:0] FOLLOW_MIN = 16'h0005;
  localparam logic [15:0] FOLLOW_MAX = 16'h8CA0;
  localparam logic [15:0] FOLLOW_RST = 16'h0014;
  // Fixed hold of mode 7, 2 s in tenths.
  localparam logic [15:0] MODE7_HOLD = 16'h0014;
  // Register byte offsets.
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_FOLLOW = 4'h4;
  localparam logic [3:0] ADR_DRX = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hC;
  // Position of the hardware handshake bit in the control word.
  localparam int CTRL_HS_BIT = 4;
  // Phase of the paging cycle.
  typedef enum logic [2:0] {PH_SLEEP, PH_LISTEN, PH_RXWIN, PH_WAKE, PH_HOLD} swc_phase_e;
  // Control word: handshake setting and functionality level.
  typedef struct packed {logic hs_hw; logic [3:0] fun;} swc_ctrl_s;
  // Status word shown to software.
  typedef struct packed {logic listen; logic sim_ok; logic clear; logic uart; logic saving;} swc_status_s;
endpackage : swc_pkg

// ### design/swc_sleep_ctrl.sv
// Power-saving level control, paging-cycle CTS timing and wake-up handling.
// Assumes a 20 MHz clock, a classic Wishbone master and two host UART ports.
//
// The Wishbone register port and the register addresses were left to the implementer.
module swc_sleep_ctrl import swc_pkg::*; #(
  parameter int FRAME_C = FRAME_CYC,
  parameter int LISTEN_C = LISTEN_CYC,
  parameter int TENTH_C = TENTH_CYC,
  parameter int WAKE_C = WAKE_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host pins, asynchronous.
  input wire logic host_request_line_a,
  input wire logic host_request_line_b,
  input wire logic serial_port_a_rx,
  input wire logic serial_port_b_rx,
  input wire logic sim_ready,
  // Modem events, same clock.
  input wire logic wake_event,
  input wire logic tx_pending,
  input wire logic session_busy,
  // Outputs.
  output logic device_clear_line_a,
  output logic device_clear_line_b,
  output logic uart_enable,
  output logic saving_active
);
  localparam int LW = (WAKE_C > LISTEN_C) ? WAKE_C : LISTEN_C;
  localparam int CW = $clog2(LW + 1);
  // Synchronised pins: rts a, rts b, rx a, rx b, sim.
  logic [4:0] pin_s;
  // Previous synchronised rts and rx levels for edge detection.
  logic [3:0] pin_d;
  // Enable pulses from the dividers.
  logic frame_tick;
  logic tenth_tick;
  // Control, configuration and status registers.
  swc_ctrl_s ctrl_r;
  logic [15:0] follow_r;
  logic [3:0] drx_r;
  swc_status_s st_r;
  swc_status_s st_nxt;
  // Paging phase, slot counter and hold counter.
  swc_phase_e phase_r;
  swc_phase_e phase_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic [8:0] frame_r;
  logic page_start;
  // Decoded conditions.
  logic rts_fall;
  logic rx_start;
  logic sim_ok;
  logic cyclic;
  logic saving_eff;
  logic reload;
  logic [15:0] hold_val;
  logic wr_go;
  logic wr_ctrl;
  logic [3:0] wr_fun;

  // Pin synchroniser.
  swc_sync #(.W(5)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in({sim_ready, serial_port_b_rx, serial_port_a_rx, host_request_line_b, host_request_line_a}),
    .rst_val(5'h1F),
    .sync_out(pin_s)
  );

  // Frame tick.
  swc_tick #(.PERIOD(FRAME_C)) u_frame (
    .clock(clock),
    .rst(rst),
    .tick(frame_tick)
  );

  // Tenth-second tick.
  swc_tick #(.PERIOD(TENTH_C)) u_tenth (
    .clock(clock),
    .rst(rst),
    .tick(tenth_tick)
  );

  // Edge detection on the synchronised host lines.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_d <= 4'hF;
    end else begin
      pin_d <= pin_s[3:0];
    end
  end

  // Either request line falling, either receive line starting a character.
  assign rts_fall = (pin_d[0] & ~pin_s[0]) | (pin_d[1] & ~pin_s[1]);
  assign rx_start = (pin_d[2] & ~pin_s[2]) | (pin_d[3] & ~pin_s[3]);
  assign sim_ok = pin_s[4];
  assign cyclic = (ctrl_r.fun == FUN_C7) || (ctrl_r.fun == FUN_C9);
  assign saving_eff = (ctrl_r.fun != FUN_FULL) && sim_ok;
  assign reload = tx_pending || wake_event || session_busy;
  assign hold_val = (ctrl_r.fun == FUN_C9) ? follow_r : MODE7_HOLD;

  // Paging multiframe counter.
  // interval is 51 frames times factor
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_r <= '0;
    end else if (frame_tick) begin
      frame_r <= page_start ? '0 : frame_r + 1'b1;
    end
  end
  assign page_start = frame_tick && (frame_r == 9'(FRAMES_PER_PAGE * int'(drx_r) - 1));

  // Bus writes land at the acknowledge edge and need the serial side awake.
  // commands refused while asleep
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && st_r.uart;
  assign wr_fun = wb_dat_i[3:0];
  assign wr_ctrl = wr_go && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] &&
                   ((wr_fun == FUN_NC) || (wr_fun == FUN_FULL) ||
                    (((wr_fun == FUN_C7) || (wr_fun == FUN_C9)) && wb_dat_i[CTRL_HS_BIT]));

  // Control register and functionality level.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= '{hs_hw: 1'b0, fun: FUN_FULL};
    end else if (wr_ctrl) begin
      ctrl_r <= '{hs_hw: wb_dat_i[CTRL_HS_BIT], fun: wr_fun};
    end else if (wr_go && (wb_adr_i == ADR_CTRL) && wb_sel_i[0]) begin
      // Rejected level code: only the handshake bit is taken.
      ctrl_r.hs_hw <= wb_dat_i[CTRL_HS_BIT];
    end else if ((ctrl_r.fun == FUN_NC) && (rts_fall || wake_event)) begin
      ctrl_r.fun <= FUN_FULL;
    end
  end

  // Configuration registers, out-of-range values ignored.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      follow_r <= FOLLOW_RST;
      drx_r <= DRX_RST;
    end else if (wr_go) begin
      if ((wb_adr_i == ADR_FOLLOW) && (wb_sel_i[1:0] == 2'h3) &&
          (wb_dat_i[15:0] >= FOLLOW_MIN) && (wb_dat_i[15:0] <= FOLLOW_MAX)) begin
        follow_r <= wb_dat_i[15:0];
      end
      if ((wb_adr_i == ADR_DRX) && wb_sel_i[0] && (wb_dat_i[3:0] >= DRX_MIN) && (wb_dat_i[3:0] <= DRX_MAX)) begin
        drx_r <= wb_dat_i[3:0];
      end
    end
  end

  // Phase sequencing of the paging cycle and the hold timer.
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    hold_nxt = hold_r;
    if (!saving_eff) begin
      // Full level or no SIM: only a pending RTS wake delay runs on.
      if ((ctrl_r.fun == FUN_NC) && rts_fall && !sim_ok) begin
        phase_nxt = PH_SLEEP;
      end else if (phase_r == PH_WAKE) begin
        phase_nxt = (cnt_r == '0) ? PH_SLEEP : PH_WAKE;
      end else begin
        phase_nxt = PH_SLEEP;
      end
    end else if ((ctrl_r.fun == FUN_NC) && (rts_fall || wake_event)) begin
      phase_nxt = rts_fall ? PH_WAKE : PH_SLEEP;
      cnt_nxt = CW'(WAKE_C - 1);
    end else if (cyclic && reload) begin
      phase_nxt = PH_HOLD;
      hold_nxt = hold_val;
    end else if (cyclic && rts_fall && (phase_r == PH_HOLD)) begin
      hold_nxt = hold_val;
    end else if ((ctrl_r.fun == FUN_C9) && rts_fall && (phase_r != PH_WAKE)) begin
      phase_nxt = PH_WAKE;
      cnt_nxt = CW'(WAKE_C - 1);
    end else begin
      unique case (phase_r)
        PH_SLEEP: begin
          if (page_start) begin
            phase_nxt = PH_LISTEN;
            cnt_nxt = CW'(LISTEN_C - 1);
          end
        end
        PH_LISTEN: begin
          if (cyclic && rx_start) begin
            phase_nxt = PH_HOLD;
            hold_nxt = hold_val;
          end else if (cnt_r == '0) begin
            // 5 ms CTS then 5 ms UART
            phase_nxt = cyclic ? PH_RXWIN : PH_SLEEP;
            cnt_nxt = CW'(LISTEN_C - 1);
          end
        end
        PH_RXWIN: begin
          if (rx_start) begin
            phase_nxt = PH_HOLD;
            hold_nxt = hold_val;
          end else if (cnt_r == '0) begin
            phase_nxt = PH_SLEEP;
          end
        end
        PH_WAKE: begin
          if (cnt_r == '0) begin
            phase_nxt = PH_HOLD;
            hold_nxt = hold_val;
          end
        end
        PH_HOLD: begin
          if (rx_start) begin
            hold_nxt = hold_val;
          end else if (hold_r == '0) begin
            phase_nxt = PH_SLEEP;
          end else if (tenth_tick) begin
            hold_nxt = hold_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Phase and counter state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_r <= PH_SLEEP;
      cnt_r <= '0;
      hold_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Output status from the phase.
  always_comb begin
    st_nxt.sim_ok = sim_ok;
    st_nxt.listen = saving_eff && ((phase_r == PH_LISTEN) || (phase_r == PH_RXWIN));
    if (!saving_eff) begin
      st_nxt.uart = (phase_r != PH_WAKE);
      st_nxt.clear = (phase_r != PH_WAKE);
    end else begin
      // CTS low only while UART on
      st_nxt.uart = cyclic && (phase_r != PH_SLEEP) && (phase_r != PH_WAKE);
      st_nxt.clear = cyclic && ((phase_r == PH_LISTEN) || (phase_r == PH_HOLD));
    end
    st_nxt.saving = saving_eff && (phase_r == PH_SLEEP);
  end

  // Registered status drives all pins; the clear lines get their own active-low flops.
  // both ports share one CTS
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{listen: 1'b0, sim_ok: 1'b0, clear: 1'b1, uart: 1'b1, saving: 1'b0};
      device_clear_line_a <= 1'b0;
      device_clear_line_b <= 1'b0;
    end else begin
      st_r <= st_nxt;
      device_clear_line_a <= ~st_nxt.clear;
      device_clear_line_b <= ~st_nxt.clear;
    end
  end

  // Remaining pins come straight from the status flops.
  assign uart_enable = st_r.uart;
  assign saving_active = st_r.saving;

  // Wishbone acknowledge and read data, one wait state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        unique case (wb_adr_i)
          ADR_CTRL: wb_dat_o <= {27'h0, ctrl_r};
          ADR_FOLLOW: wb_dat_o <= {16'h0, follow_r};
          ADR_DRX: wb_dat_o <= {28'h0, drx_r};
          ADR_STATUS: wb_dat_o <= {27'h0, st_r};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Checks on the controller.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_listen_end;
    (phase_r == PH_LISTEN) && (cnt_r == '0) && cyclic && saving_eff && !reload && !rts_fall && !rx_start;
  endsequence

  a_reset_level: assert property ($fell(rst) |-> ctrl_r.fun == FUN_FULL)
    else $error("level not full after reset");
  a_nc_blocked: assert property ((ctrl_r.fun == FUN_NC) && sim_ok && (phase_r != PH_WAKE) && !wake_event && !rts_fall
                                 ##1 1 |=> !uart_enable)
    else $error("uart open in level zero");
  a_nc_rts_quit: assert property ((ctrl_r.fun == FUN_NC) && rts_fall && !wr_ctrl |=> ctrl_r.fun == FUN_FULL)
    else $error("rts did not quit level zero");
  a_no_sim_save: assert property (!sim_ok |=> !saving_active)
    else $error("saving without sim");
  a_lines_equal: assert property (device_clear_line_a == device_clear_line_b)
    else $error("clear lines differ");
  a_m7_rts_quiet: assert property ((ctrl_r.fun == FUN_C7) && (phase_r == PH_SLEEP) && rts_fall && !reload
                                   && !page_start && saving_eff |=> phase_r == PH_SLEEP)
    else $error("rts woke mode seven");
  a_listen_clear: assert property ((phase_r == PH_LISTEN) && cyclic && saving_eff |=> !device_clear_line_a)
    else $error("cts high in listen slot");
  a_listen_to_rx: assert property (s_listen_end |=> (phase_r == PH_RXWIN) ##1 device_clear_line_a)
    else $error("listen slot did not hand over");
  a_hold_expire: assert property ((phase_r == PH_HOLD) && (hold_r == '0) && !reload && !rx_start
                                  && !rts_fall && saving_eff |=> phase_r == PH_SLEEP)
    else $error("hold did not expire");
  a_tx_opens: assert property (cyclic && saving_eff && tx_pending |=> ##1 uart_enable && !device_clear_line_a)
    else $error("pending tx did not open uart");
endmodule // swc_sleep_ctrl

// ### design/swc_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static against the clock period.
module swc_sync import swc_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Pins in, synchronised levels out.
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);
  // First stage, read only by the second stage.
  logic [W-1:0] meta_r;

  // One two-flop chain per bit; idle level after reset is high.
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        meta_r[g] <= 1'b1;
        sync_out[g] <= 1'b1;
      end else begin
        meta_r[g] <= pin_in[g];
        sync_out[g] <= meta_r[g];
      end
    end
  end
endmodule // swc_sync

// ### design/swc_tick.sv
// Free-running divider giving a one-cycle enable pulse every PERIOD cycles.
// Assumes PERIOD is at least two.
module swc_tick import swc_pkg::*; #(
  parameter int PERIOD = FRAME_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Enable pulse.
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  // Cycle counter.
  logic [CW-1:0] cnt_r;

  // Counts down and pulses at the wrap.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == '0);
      cnt_r <= (cnt_r == '0) ? CW'(PERIOD - 1) : cnt_r - 1'b1;
    end
  end
endmodule // swc_tick

// ### verification/swc_host_model.sv
// Host processor model: two UART ports with RTS/CTS flow control.
// Assumes the bench clock and active-low clear lines from the device.
module swc_host_model #(
  parameter int BIT_C = 2
) (
  // Clock.
  input wire logic clock,
  // Device clear lines, low means ready.
  input wire logic device_clear_line_a,
  input wire logic device_clear_line_b,
  // Request and transmit lines, idle high.
  output logic host_request_line_a,
  output logic host_request_line_b,
  output logic serial_port_a_rx,
  output logic serial_port_b_rx
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels from time zero, so the device sees no false edge.
  initial begin
    host_request_line_a = 1'b1;
    host_request_line_b = 1'b1;
    serial_port_a_rx = 1'b1;
    serial_port_b_rx = 1'b1;
  end

  // Moves one request line just after a clock edge.
  task automatic set_rts(input int line, input logic lvl);
    @(posedge clock);
    if (line == 0) begin
      host_request_line_a <= lvl;
    end else begin
      host_request_line_b <= lvl;
    end
  endtask

  // Sends one framed character, low bit first, then returns the line to idle high.
  task automatic send_char(input int port, input logic [7:0] ch);
    logic [9:0] fr;
    int n;
    fr = {1'b1, ch, 1'b0};
    n = 0;
    while (device_clear_line_a !== 1'b0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      if (port == 0) begin
        serial_port_a_rx <= fr[i];
      end else begin
        serial_port_b_rx <= fr[i];
      end
      repeat (BIT_C - 1) @(posedge clock);
    end
  endtask
endmodule // swc_host_model

// ### verification/tb_sleep_mode_cts_wake_control.sv
// Self-checking bench of the sleep and CTS wake controller.
// Assumes shortened timing parameters and the host model beside the device.
module tb_sleep_mode_cts_wake_control;
  import swc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened frame, listen slot, tenth tick and wake delay.
  localparam int FR = 20;
  localparam int LI = 8;
  localparam int TE = 4;
  localparam int WK = 6;
  logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sim_ready;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic rq_a, rq_b, rx_a, rx_b, wake_event, tx_pending, session_busy;
  logic device_clear_line_a, device_clear_line_b, uart_enable, saving_active;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // Expected read data with the bits that matter.
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} swc_note_s;
  swc_note_s notes[$];

  swc_sleep_ctrl #(.FRAME_C(FR), .LISTEN_C(LI), .TENTH_C(TE), .WAKE_C(WK)) DUT (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .host_request_line_a(rq_a), .host_request_line_b(rq_b),
    .serial_port_a_rx(rx_a), .serial_port_b_rx(rx_b), .sim_ready(sim_ready),
    .wake_event(wake_event), .tx_pending(tx_pending), .session_busy(session_busy),
    .device_clear_line_a(device_clear_line_a), .device_clear_line_b(device_clear_line_b),
    .uart_enable(uart_enable), .saving_active(saving_active));

  swc_host_model host (
    .clock(clock), .device_clear_line_a(device_clear_line_a), .device_clear_line_b(device_clear_line_b),
    .host_request_line_a(rq_a), .host_request_line_b(rq_b), .serial_port_a_rx(rx_a), .serial_port_b_rx(rx_b));

  // Clock of 50 ns period and a free cycle counter.
  always #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  // Counts a comparison and reports a difference.
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // Checks that a measured span lies in a window.
  task automatic rng(int v, int lo, int hi, string what);
    check(32'(v >= lo && v <= hi), 32'h1, what);
  endtask

  // One classic Wishbone cycle; reads leave a note for the monitor.
  task automatic bus(logic we, logic [3:0] a, logic [31:0] d, logic [31:0] e, logic [31:0] m);
    int n;
    n = 0;
    if (!we) notes.push_back('{e, m});
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1, "bus answer");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Read monitor: takes the oldest note at each read acknowledge.
  always @(posedge clock) begin
    swc_note_s nt;
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
      if (notes.size() == 0) begin
        check(32'h0, 32'h1, "read without note");
      end else begin
        nt = notes.pop_front();
        check(wb_dat_o & nt.mask, nt.exp, "read data");
      end
    end
  end

  // Both clear lines match; a sleeping device shows CTS high and UART off.
  always @(negedge clock) begin
    if (rst === 1'b0) begin
      check(32'(device_clear_line_b), 32'(device_clear_line_a), "port b clear");
      if (saving_active !== 1'b0) check({device_clear_line_a, uart_enable}, 2'b10, "sleep pins");
    end
  end

  // Picks an output to wait on: 0 clear line, 1 UART, 2 saving.
  function automatic logic pick(int s);
    case (s)
      0: return device_clear_line_a;
      1: return uart_enable;
      default: return saving_active;
    endcase
  endfunction

  // Waits under a bound for an output level.
  task automatic wait_for(int s, logic v, int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) check(32'(s), 32'hFF, "wait expired");
  endtask

  // Waits for a listen, records its start and waits for the pause after it.
  task automatic to_pause(output int tf);
    wait_for(0, 1'b0, 6000);
    tf = cyc;
    wait_for(1, 1'b0, 6000);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the longest expected run.
  initial begin
    #(90000 * 50);
    bad_count++;
    $display("[ERR] %0t watchdog", $time);
    end_sim;
  end

  initial begin
    int k, t, u;
    logic [31:0] r;
    {clock, rst, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h08;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {4'h0, 4'hF, 32'h0};
    {sim_ready, wake_event, tx_pending, session_busy} = 4'h8;
    r = $urandom(32'h2B76DF5D);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    bus(0, ADR_CTRL, 0, 32'h01, 32'h1F);
    bus(0, ADR_FOLLOW, 0, 32'(FOLLOW_RST), 32'hFFFF);
    bus(0, 4'h1, 0, 32'h0, 32'hFFFFFFFF);
    check({device_clear_line_a, uart_enable, saving_active}, 3'b010, "reset pins");
    $display("test reset done");
    // Paging timing with a random reception factor.
    k = $urandom_range(5, 2);
    bus(1, ADR_DRX, 32'h9, 0, 0);
    bus(0, ADR_DRX, 0, 32'h9, 32'hF);
    bus(1, ADR_DRX, 32'hA, 0, 0);
    bus(1, ADR_DRX, 32'(k), 0, 0);
    bus(0, ADR_DRX, 0, 32'(k), 32'hF);
    r = $urandom;
    bus(1, ADR_CTRL, {r[31:5], 5'h07}, 0, 0);
    bus(0, ADR_CTRL, 0, 32'h01, 32'h1F);
    bus(1, ADR_CTRL, {r[31:5], 5'h17}, 0, 0);
    bus(0, ADR_CTRL, 0, 32'h17, 32'h1F);
    wait_for(2, 1'b1, 6000);
    wait_for(0, 1'b0, 6000);
    t = cyc;
    wait_for(0, 1'b1, 20);
    check(32'(cyc - t), 32'(LI), "listen slot");
    wait_for(1, 1'b0, 40);
    check(32'(cyc - t), 32'(2 * LI), "uart slot");
    bus(1, ADR_FOLLOW, 32'h30, 0, 0);
    bus(0, ADR_FOLLOW, 0, 32'(FOLLOW_RST), 32'hFFFF);
    host.set_rts(0, 1'b0);
    repeat (20) @(posedge clock);
    check(32'(device_clear_line_a), 32'h1, "mode seven request");
    host.set_rts(0, 1'b1);
    wait_for(0, 1'b0, 6000);
    check(32'(cyc - t), 32'(51 * k * FR), "paging interval");
    $display("test paging done");
    // Start bit inside the listen slot keeps the interface up.
    t = cyc;
    host.send_char(0, 8'hFF);
    wait_for(0, 1'b1, 300);
    rng(cyc - t, int'(MODE7_HOLD) * TE, int'(MODE7_HOLD) * TE + TE + 30, "rx hold");
    bus(0, ADR_CTRL, 0, 32'h17, 32'h1F);
    $display("test receive window done");
    // Wake events in mode seven are temporary.
    for (int e = 0; e < 3; e++) begin
      to_pause(u);
      t = cyc;
      if (e == 0) begin
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
      end else if (e == 1) begin
        tx_pending <= 1'b1;
      end else begin
        session_busy <= 1'b1;
      end
      wait_for(0, 1'b0, 8);
      if (e > 0) begin
        repeat (30) @(posedge clock);
        tx_pending <= 1'b0;
        session_busy <= 1'b0;
        t = cyc;
      end
      wait_for(0, 1'b1, 200);
      rng(cyc - t, int'(MODE7_HOLD) * TE - 4, int'(MODE7_HOLD) * TE + TE + 6, "event hold");
      bus(0, ADR_CTRL, 0, 32'h17, 32'h1F);
    end
    $display("test events done");
    // Level one written during a hold ends cyclic sleep.
    to_pause(u);
    tx_pending <= 1'b1;
    wait_for(0, 1'b0, 8);
    bus(1, ADR_CTRL, 32'h11, 0, 0);
    tx_pending <= 1'b0;
    repeat (TE * 30) @(posedge clock);
    check({device_clear_line_a, uart_enable, saving_active}, 3'b010, "full level pins");
    bus(0, ADR_CTRL, 0, 32'h11, 32'h1F);
    $display("test leave sleep done");
    // Mode nine: follow-up bounds and request wake-up on port b.
    bus(1, ADR_FOLLOW, 32'h4, 0, 0);
    bus(1, ADR_FOLLOW, 32'h8CA1, 0, 0);
    bus(1, ADR_FOLLOW, 32'h5, 0, 0);
    bus(0, ADR_FOLLOW, 0, 32'h5, 32'hFFFF);
    bus(1, ADR_CTRL, 32'h19, 0, 0);
    to_pause(u);
    host.set_rts(1, 1'b0);
    t = cyc;
    wait_for(0, 1'b0, WK + 12);
    rng(cyc - t, WK, WK + 10, "wake delay");
    t = cyc;
    wait_for(0, 1'b1, 100);
    rng(cyc - t, 5 * TE - 4, 6 * TE + 6, "mode nine hold");
    host.set_rts(1, 1'b1);
    bus(0, ADR_CTRL, 0, 32'h19, 32'h1F);
    $display("test mode nine done");
    // Level zero: serial blocked, then woken by an event and by a request.
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    wait_for(0, 1'b0, 8);
    bus(1, ADR_CTRL, 32'h10, 0, 0);
    wait_for(2, 1'b1, 6000);
    u = 0;
    repeat (3000) begin
      @(posedge clock);
      if (uart_enable !== 1'b0) u++;
    end
    check(32'(u), 32'h0, "level zero serial");
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    wait_for(1, 1'b1, 10);
    bus(0, ADR_CTRL, 0, 32'h11, 32'h1F);
    bus(1, ADR_CTRL, 32'h10, 0, 0);
    wait_for(2, 1'b1, 6000);
    host.set_rts(1, 1'b0);
    wait_for(0, 1'b0, WK + 12);
    bus(0, ADR_CTRL, 0, 32'h11, 32'h1F);
    host.set_rts(1, 1'b1);
    $display("test level zero done");
    // Without a ready card the level is kept but saving never starts.
    sim_ready <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1, ADR_CTRL, 32'h17, 0, 0);
    bus(0, ADR_CTRL, 0, 32'h17, 32'h1F);
    u = 0;
    repeat (3000) begin
      @(posedge clock);
      if (saving_active !== 1'b0) u++;
    end
    check(32'(u), 32'h0, "no card saving");
    $display("test no card done");
    end_sim;
  end
endmodule // tb_sleep_mode_cts_wake_control
